/* src/see_front.sv */
// Two-wire slave front end of a serial EEPROM: conditions, addressing, ack, program timer.
// Assumes an array beside it that reads rd_data for rd_addr combinationally, same clock.
`timescale 1ns/1ps
`default_nettype none

module see_front #(
	parameter int PWRUP_CYC = see_pkg::PWRUP_CYC,
	parameter int PROG_CYC = see_pkg::PROG_CYC,
	parameter int GLITCH_NS = see_pkg::GLITCH_NS,
	parameter logic [3:0] TYPE_CODE = see_pkg::TYPE_CODE_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Straps and supply monitor
	input wire logic dev_sel_bit0,
	input wire logic dev_sel_bit1,
	input wire logic dev_sel_bit2,
	input wire logic write_inhibit,
	input wire logic supply_ok,
	// Write stream to the page buffer
	output see_pkg::see_wr_s wr_word,
	output logic wr_valid,
	input wire logic wr_ready,
	// Read port of the array
	output logic [see_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [see_pkg::BYTE_W-1:0] rd_data,
	// Status
	output logic prog_start,
	output logic prog_busy,
	output logic dev_ready
);

	localparam int GL_RAW = (GLITCH_NS + see_pkg::CLK_NS - 1) / see_pkg::CLK_NS;
	localparam logic [see_pkg::FLT_W-1:0] GL_CYC = see_pkg::FLT_W'((GL_RAW < 1) ? 1 : GL_RAW);
	localparam logic [see_pkg::TMR_W-1:0] PU_LAST = see_pkg::TMR_W'(PWRUP_CYC - 1);
	localparam logic [see_pkg::TMR_W-1:0] PROG_LAST = see_pkg::TMR_W'(PROG_CYC - 1);

	see_pkg::see_pins_s pins_raw, sync1_r, sync2_r;
	logic [1:0] flt;
	logic scl_f, sda_f, scl_d_r, sda_d_r;
	see_pkg::see_state_e state_r, state_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	logic [see_pkg::BYTE_W-1:0] shift_r, shift_nxt;
	logic oe_n_r, oe_n_nxt;
	logic [1:0] bidx_r;
	logic rd_mode_r, mack_r, wp_lat_r, data_seen_r, write_pend_r;
	logic [see_pkg::ADDR_W-1:0] addr_r;
	logic [see_pkg::TMR_W-1:0] pu_cnt_r, prog_cnt_r;
	logic prog_busy_r, prog_start_r, ready_r;
	see_pkg::see_wr_s slot0_r, slot1_r;
	logic v0_r, v1_r;

	// Every pin crosses two flops before anything looks at it
	assign pins_raw = '{supply_ok: supply_ok, wp: write_inhibit,
		sel: {dev_sel_bit2, dev_sel_bit1, dev_sel_bit0}, scl: scl_in, sda: sda_in};
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_r <= see_pkg::PINS_IDLE;
			sync2_r <= see_pkg::PINS_IDLE;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end

	// A level is only accepted after it outlasts the glitch width
	for (genvar gi = 0; gi < 2; gi++) begin : g_flt
		logic [see_pkg::FLT_W-1:0] cnt_r;
		logic lvl_r;
		logic raw;
		assign raw = (gi == 0) ? sync2_r.sda : sync2_r.scl;
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				cnt_r <= '0;
				lvl_r <= 1'b1;
			end else if (raw == lvl_r) begin
				cnt_r <= '0;
			end else if (cnt_r == GL_CYC) begin
				lvl_r <= raw;
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + see_pkg::FLT_W'(1);
			end
		end
		assign flt[gi] = lvl_r;
	end
	assign sda_f = flt[0];
	assign scl_f = flt[1];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_f;
			sda_d_r <= sda_f;
		end
	end

	// Bus events and decisions
	wire logic supply_up = sync2_r.supply_ok;
	wire logic scl_rise = scl_f & ~scl_d_r;
	wire logic scl_fall = ~scl_f & scl_d_r;
	wire logic start_c = scl_f & scl_d_r & sda_d_r & ~sda_f;
	wire logic stop_c = scl_f & scl_d_r & ~sda_d_r & sda_f;
	wire logic live = (state_r != see_pkg::SEE_RESET) && (state_r != see_pkg::SEE_PWRUP);
	wire logic byte_done = (bit_cnt_r == see_pkg::BITS_PER_BYTE);
	wire logic rx_end = (state_r == see_pkg::SEE_RX) && scl_fall && byte_done;
	wire logic type_ok = (shift_r[7:4] == TYPE_CODE);
	wire logic sel_ok = (shift_r[3:1] == sync2_r.sel);
	wire logic dev_match = type_ok && sel_ok && !prog_busy_r;
	wire logic buf_in_ready = !v1_r;
	wire logic data_ok = !rd_mode_r && !wp_lat_r && buf_in_ready;
	wire logic ack_now = (bidx_r == see_pkg::BIDX_DEV) ? dev_match :
		(bidx_r == see_pkg::BIDX_DATA) ? data_ok : !rd_mode_r;
	wire logic push = rx_end && (bidx_r == see_pkg::BIDX_DATA) && data_ok;
	wire logic pop = v0_r && wr_ready;
	wire logic wp_strobe = (state_r == see_pkg::SEE_ACK) && scl_fall &&
		(bidx_r == see_pkg::BIDX_DATA) && !data_seen_r;
	wire logic launch = live && stop_c && write_pend_r;
	wire see_pkg::see_wr_s in_word = '{addr: addr_r, data: shift_r};

	// Bit engine next state
	always_comb begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		oe_n_nxt = oe_n_r;
		if (!supply_up) begin
			state_nxt = see_pkg::SEE_RESET;
			oe_n_nxt = 1'b1;
		end else if (state_r == see_pkg::SEE_RESET) begin
			state_nxt = see_pkg::SEE_PWRUP;
		end else if (state_r == see_pkg::SEE_PWRUP) begin
			if (pu_cnt_r == PU_LAST)
				state_nxt = see_pkg::SEE_STANDBY;
		end else if (start_c) begin
			state_nxt = see_pkg::SEE_RX;
			bit_cnt_nxt = '0;
			oe_n_nxt = 1'b1;
		end else if (stop_c) begin
			state_nxt = see_pkg::SEE_STANDBY;
			oe_n_nxt = 1'b1;
		end else begin
			unique case (state_r)
			see_pkg::SEE_RX: begin
				if (scl_rise && !byte_done) begin
					shift_nxt = {shift_r[6:0], sda_f};
					bit_cnt_nxt = bit_cnt_r + 4'h1;
				end else if (rx_end) begin
					state_nxt = ack_now ? see_pkg::SEE_ACK : see_pkg::SEE_IGNORE;
					oe_n_nxt = !ack_now;
				end
			end
			see_pkg::SEE_ACK: begin
				if (scl_fall) begin
					bit_cnt_nxt = '0;
					if (rd_mode_r) begin
						state_nxt = see_pkg::SEE_TX;
						shift_nxt = rd_data;
						oe_n_nxt = rd_data[7];
						bit_cnt_nxt = 4'h1;
					end else begin
						state_nxt = see_pkg::SEE_RX;
						oe_n_nxt = 1'b1;
					end
				end
			end
			see_pkg::SEE_TX: begin
				if (scl_fall) begin
					if (byte_done) begin
						state_nxt = see_pkg::SEE_TXACK;
						oe_n_nxt = 1'b1;
					end else begin
						shift_nxt = {shift_r[6:0], 1'b1};
						oe_n_nxt = shift_r[6];
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end
				end
			end
			see_pkg::SEE_TXACK: begin
				if (scl_fall) begin
					state_nxt = mack_r ? see_pkg::SEE_TX : see_pkg::SEE_IGNORE;
					shift_nxt = rd_data;
					oe_n_nxt = mack_r ? rd_data[7] : 1'b1;
					bit_cnt_nxt = 4'h1;
				end
			end
			// Standby and ignore wait for START or STOP
			see_pkg::SEE_STANDBY, see_pkg::SEE_IGNORE: state_nxt = state_r;
			default: state_nxt = see_pkg::SEE_RESET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= see_pkg::SEE_RESET;
			bit_cnt_r <= '0;
			shift_r <= '0;
			oe_n_r <= 1'b1;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ready_r <= (state_nxt != see_pkg::SEE_RESET) && (state_nxt != see_pkg::SEE_PWRUP);
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// Command context
	always_ff @(posedge clk) begin
		if (sys_rst || !supply_up) begin
			bidx_r <= see_pkg::BIDX_DEV;
			rd_mode_r <= 1'b0;
			data_seen_r <= 1'b0;
			wp_lat_r <= 1'b0;
		end else if (start_c) begin
			bidx_r <= see_pkg::BIDX_DEV;
			data_seen_r <= 1'b0;
		end else if (rx_end && ack_now) begin
			if (bidx_r == see_pkg::BIDX_DEV)
				rd_mode_r <= shift_r[0];
			if (bidx_r != see_pkg::BIDX_DATA)
				bidx_r <= bidx_r + 2'h1;
			else
				data_seen_r <= 1'b1;
		end else if (wp_strobe) begin
			wp_lat_r <= sync2_r.wp;
		end
	end

	// Byte address: page wrap on writes, whole array wrap on reads
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_r <= '0;
		end else if (rx_end && ack_now && bidx_r == see_pkg::BIDX_AHI) begin
			addr_r[see_pkg::ADDR_W-1:see_pkg::BYTE_W] <= shift_r[6:0];
		end else if (rx_end && ack_now && bidx_r == see_pkg::BIDX_ALO) begin
			addr_r[see_pkg::BYTE_W-1:0] <= shift_r;
		end else if (push) begin
			addr_r[see_pkg::PAGE_W-1:0] <= addr_r[see_pkg::PAGE_W-1:0] + 6'h01;
		end else if (state_r == see_pkg::SEE_TX && scl_fall && byte_done) begin
			addr_r <= addr_r + 15'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			mack_r <= 1'b0;
		else if (state_r == see_pkg::SEE_TXACK && scl_rise)
			mack_r <= !sda_f;
	end

	// Power-up delay and program cycle timers
	always_ff @(posedge clk) begin
		if (sys_rst || state_r != see_pkg::SEE_PWRUP)
			pu_cnt_r <= '0;
		else
			pu_cnt_r <= pu_cnt_r + see_pkg::TMR_W'(1);
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !supply_up) begin
			write_pend_r <= 1'b0;
			prog_busy_r <= 1'b0;
			prog_start_r <= 1'b0;
			prog_cnt_r <= '0;
		end else begin
			prog_start_r <= launch;
			if (push)
				write_pend_r <= 1'b1;
			else if (stop_c)
				write_pend_r <= 1'b0;
			if (launch) begin
				prog_busy_r <= 1'b1;
				prog_cnt_r <= '0;
			end else if (prog_busy_r) begin
				prog_cnt_r <= prog_cnt_r + see_pkg::TMR_W'(1);
				if (prog_cnt_r == PROG_LAST)
					prog_busy_r <= 1'b0;
			end
		end
	end

	// Two-entry buffer; a full buffer turns into a data-byte nack, so nothing is lost
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			v0_r <= 1'b0;
			v1_r <= 1'b0;
			slot0_r <= '0;
			slot1_r <= '0;
		end else if (pop && v1_r) begin
			slot0_r <= slot1_r;
			slot1_r <= in_word;
			v1_r <= push;
		end else if (pop) begin
			slot0_r <= in_word;
			v0_r <= push;
		end else if (push && !v0_r) begin
			slot0_r <= in_word;
			v0_r <= 1'b1;
		end else if (push) begin
			slot1_r <= in_word;
			v1_r <= 1'b1;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_r;
	assign wr_word = slot0_r;
	assign wr_valid = v0_r;
	assign rd_addr = addr_r;
	assign prog_start = prog_start_r;
	assign prog_busy = prog_busy_r;
	assign dev_ready = ready_r;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence ack_held;
		(!oe_n_r && state_r == see_pkg::SEE_ACK) [*2];
	endsequence
	sequence prog_launch;
		prog_busy_r && prog_start_r ##1 prog_busy_r && !prog_start_r;
	endsequence
	drive_states_a: assert property (!oe_n_r |->
		state_r inside {see_pkg::SEE_ACK, see_pkg::SEE_TX})
		else $error("data line pulled low outside ack or transmit");
	ack_hold_a: assert property (supply_up && !start_c && !stop_c && rx_end && ack_now
		|=> ack_held) else $error("acknowledge not held low");
	sel_nack_a: assert property (supply_up && !start_c && !stop_c && rx_end
		&& bidx_r == see_pkg::BIDX_DEV && !sel_ok |=> oe_n_r && state_r == see_pkg::SEE_IGNORE)
		else $error("foreign address acknowledged");
	busy_nack_a: assert property (prog_busy_r && rx_end && bidx_r == see_pkg::BIDX_DEV
		|=> oe_n_r) else $error("address acknowledged during program cycle");
	wp_reject_a: assert property (rx_end && bidx_r == see_pkg::BIDX_DATA && wp_lat_r
		|-> !push ##1 oe_n_r) else $error("write accepted while inhibited");
	start_restart_a: assert property (supply_up && live && start_c
		|=> state_r == see_pkg::SEE_RX && bit_cnt_r == '0 && oe_n_r)
		else $error("START did not restart reception");
	stop_launch_a: assert property (supply_up && launch |=> prog_launch)
		else $error("STOP after write did not launch program cycle");
	prog_end_a: assert property (prog_busy_r && prog_cnt_r == PROG_LAST && supply_up
		|=> !prog_busy_r) else $error("program cycle overran");
	prog_bound_a: assert property (prog_busy_r |-> prog_cnt_r <= PROG_LAST)
		else $error("program counter beyond limit");
	pwrup_ready_a: assert property (state_r == see_pkg::SEE_PWRUP && pu_cnt_r == PU_LAST
		&& supply_up |=> state_r == see_pkg::SEE_STANDBY) else $error("power-up delay wrong");
	brownout_a: assert property (!supply_up |=> state_r == see_pkg::SEE_RESET && oe_n_r)
		else $error("no reset on low supply");
	tx_on_fall_a: assert property ($changed(oe_n_r) |->
		$past(scl_fall || start_c || stop_c || !supply_up))
		else $error("data output changed away from clock fall");
	page_wrap_a: assert property (push |=>
		addr_r[see_pkg::ADDR_W-1:see_pkg::PAGE_W] == $past(addr_r[see_pkg::ADDR_W-1:see_pkg::PAGE_W]))
		else $error("write address left its page");

endmodule

`default_nettype wire

/* src/see_pkg.sv */
// Shared constants, types and timing figures for the serial EEPROM bus front end.
// Assumes a single 125 MHz clock; all pin inputs are asynchronous to it.
`default_nettype none

package see_pkg;

	localparam int CLK_NS = 8;
	localparam int GLITCH_NS = 50;
	localparam int PWRUP_NS = 1000000;
	localparam int PROG_NS = 5000000;
	// Longest times round down to whole cycles
	localparam int PWRUP_CYC = PWRUP_NS / CLK_NS;
	localparam int PROG_CYC = PROG_NS / CLK_NS;
	localparam int TMR_W = 20;
	localparam int FLT_W = 4;

	localparam int ADDR_W = 15;
	localparam int BYTE_W = 8;
	localparam int PAGE_W = 6;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Memory-type code: value is arbitrary
	localparam logic [3:0] TYPE_CODE_DEF = 4'h5;

	localparam logic [1:0] BIDX_DEV = 2'h0;
	localparam logic [1:0] BIDX_AHI = 2'h1;
	localparam logic [1:0] BIDX_ALO = 2'h2;
	localparam logic [1:0] BIDX_DATA = 2'h3;

	typedef enum logic [3:0] {
		SEE_RESET, SEE_PWRUP, SEE_STANDBY, SEE_RX, SEE_ACK, SEE_TX, SEE_TXACK, SEE_IGNORE
	} see_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] data;
	} see_wr_s;

	typedef struct packed {
		logic supply_ok;
		logic wp;
		logic [2:0] sel;
		logic scl;
		logic sda;
	} see_pins_s;

	// Bus lines idle high, straps low
	localparam see_pins_s PINS_IDLE = '{supply_ok: 1'b0, wp: 1'b0, sel: 3'h0, scl: 1'b1,
		sda: 1'b1};

endpackage

`default_nettype wire

/* tb/see_master.sv */
// Behavioural two-wire bus master that drives the clock and data lines of the front end.
// Assumes the bench resolves the open-drain data wire and feeds it back on sda_line.
`timescale 1ns/1ps
`default_nettype none

module see_master (
	// Bench clock
	input wire logic clk,
	// Bus lines
	input wire logic sda_line,
	output var logic scl_out,
	output var logic sda_low
);
	// Clock idles high and stands still between frames
	initial begin
		scl_out = 1'b1;
		sda_low = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// 80 ns bit: data set mid-low, line sampled late in the high phase
	task automatic bit_xfer(input logic b, output logic got);
		cyc(2);
		sda_low = !b;
		cyc(3);
		scl_out = 1'b1;
		cyc(4);
		got = sda_line;
		cyc(1);
		scl_out = 1'b0;
	endtask

	// Long low phase first, so a device still holding ack has let go
	task automatic bus_start();
		if (!scl_out) begin
			cyc(2);
			sda_low = 1'b0;
			cyc(6);
			scl_out = 1'b1;
			cyc(5);
		end
		sda_low = 1'b1;
		cyc(5);
		scl_out = 1'b0;
	endtask

	task automatic bus_stop();
		cyc(2);
		sda_low = 1'b1;
		cyc(3);
		scl_out = 1'b1;
		cyc(5);
		sda_low = 1'b0;
		cyc(5);
	endtask

	// One-cycle clock spike during a low phase, narrower than the input filter
	task automatic spike();
		cyc(2);
		scl_out = 1'b1;
		cyc(1);
		scl_out = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(b[i], g);
		end
		bit_xfer(1'b1, g);
		ack = !g;
	endtask

	task automatic recv_byte(input logic mack, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, b[i]);
		end
		bit_xfer(!mack, g);
	endtask
endmodule

`default_nettype wire

/* tb/serial_eeprom_bus_slave_front_test.sv */
// Self-checking bench for the two-wire EEPROM front end with a bus master model.
// Assumes see_pkg and see_front are compiled first; array data is a fixed address pattern.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_bus_slave_front_test;
	localparam int PW = 20;
	// Program time must outlast one polled address byte
	localparam int PG = 200;
	localparam int CEIL = 20000;
	localparam logic [3:0] TC = see_pkg::TYPE_CODE_DEF;
	logic clk;
	logic sys_rst;
	logic supply_ok;
	logic write_inhibit;
	logic [2:0] sel_pins;
	logic wr_ready;
	logic sda_out;
	logic sda_oe_n;
	logic scl_out;
	logic sda_low;
	wire logic sda_wire;
	see_pkg::see_wr_s wr_word;
	logic wr_valid;
	logic [see_pkg::ADDR_W-1:0] rd_addr;
	logic [see_pkg::BYTE_W-1:0] rd_data;
	logic prog_start;
	logic prog_busy;
	logic dev_ready;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc_cnt = 0;

	// Pulled-up wire: low when either party pulls
	assign sda_wire = (sda_oe_n ? 1'b1 : sda_out) & !sda_low;
	assign rd_data = rd_addr[7:0] ^ 8'h5a;

	see_front #(.PWRUP_CYC(PW), .PROG_CYC(PG), .GLITCH_NS(8)) i_see_front (
		.clk(clk), .sys_rst(sys_rst), .scl_in(scl_out), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .dev_sel_bit0(sel_pins[0]),
		.dev_sel_bit1(sel_pins[1]), .dev_sel_bit2(sel_pins[2]),
		.write_inhibit(write_inhibit), .supply_ok(supply_ok), .wr_word(wr_word),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_data(rd_data),
		.prog_start(prog_start), .prog_busy(prog_busy), .dev_ready(dev_ready)
	);

	see_master i_see_master (.clk(clk), .sda_line(sda_wire), .scl_out(scl_out),
		.sda_low(sda_low));

	initial begin
		clk = 1'b0;
		forever #4 clk = !clk;
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == CEIL) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: pick = dev_ready;
			1: pick = prog_busy;
			default: pick = prog_start;
		endcase
	endfunction

	task automatic wait_lvl(input int w, input logic lvl, input int lim, output int n);
		n = 0;
		while (pick(w) !== lvl && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	task automatic tx(input logic [7:0] b, input logic exp);
		logic ack;
		i_see_master.send_byte(b, ack);
		chk(ack, exp);
	endtask

	task automatic t_powerup();
		int n;
		chk(dev_ready, 1'b0);
		supply_ok = 1'b1;
		wait_lvl(0, 1'b1, PW + 20, n);
		chk(n >= PW && n <= PW + 10, 1'b1);
		// Straps left at their pulled-down level
		i_see_master.bus_start();
		i_see_master.spike();
		tx({TC, 3'h0, 1'b0}, 1'b1);
		i_see_master.bus_stop();
		$display("test powerup done");
	endtask

	task automatic t_select();
		sel_pins = 3'h5;
		for (int i = 0; i < 8; i++) begin
			i_see_master.bus_start();
			tx({TC, i[2:0], 1'b0}, i == 5);
			i_see_master.bus_stop();
		end
		i_see_master.bus_start();
		tx({~TC, 3'h5, 1'b0}, 1'b0);
		tx(8'h00, 1'b0);
		i_see_master.bus_stop();
		$display("test select done");
	endtask

	task automatic t_write_full();
		int n;
		i_see_master.bus_start();
		tx({TC, 3'h5, 1'b0}, 1'b1);
		tx(8'h00, 1'b1);
		tx(8'hbf, 1'b1);
		tx(8'h12, 1'b1);
		tx(8'h34, 1'b1);
		// Receiver stalled: third byte finds both slots taken
		tx(8'h56, 1'b0);
		i_see_master.bus_stop();
		wait_lvl(2, 1'b1, 30, n);
		chk(n < 30, 1'b1);
		chk(prog_busy, 1'b1);
		@(posedge clk);
		#1;
		chk(prog_start, 1'b0);
		i_see_master.bus_start();
		tx({TC, 3'h5, 1'b0}, 1'b0);
		i_see_master.bus_stop();
		chk(wr_valid, 1'b1);
		chk(wr_word, {15'h00bf, 8'h12});
		wr_ready = 1'b1;
		@(posedge clk);
		#1;
		chk(wr_word, {15'h0080, 8'h34});
		@(posedge clk);
		#1;
		chk(wr_valid, 1'b0);
		wr_ready = 1'b0;
		wait_lvl(1, 1'b0, PG + 10, n);
		chk(n < PG + 10, 1'b1);
		i_see_master.bus_start();
		tx({TC, 3'h5, 1'b0}, 1'b1);
		i_see_master.bus_stop();
		$display("test write and buffer done");
	endtask

	task automatic t_inhibit();
		int n;
		write_inhibit = 1'b1;
		i_see_master.bus_start();
		tx({TC, 3'h5, 1'b0}, 1'b1);
		tx(8'h00, 1'b1);
		tx(8'h40, 1'b1);
		tx(8'h77, 1'b0);
		i_see_master.bus_stop();
		wait_lvl(2, 1'b1, 40, n);
		chk(n, 40);
		chk(wr_valid, 1'b0);
		write_inhibit = 1'b0;
		$display("test inhibit done");
	endtask

	task automatic t_read();
		logic [7:0] b;
		i_see_master.bus_start();
		tx({TC, 3'h5, 1'b0}, 1'b1);
		tx(8'h01, 1'b1);
		tx(8'h23, 1'b1);
		i_see_master.bus_start();
		tx({TC, 3'h5, 1'b1}, 1'b1);
		i_see_master.recv_byte(1'b1, b);
		chk(b, 8'h79);
		i_see_master.recv_byte(1'b0, b);
		chk(b, 8'h7e);
		i_see_master.bus_stop();
		chk(sda_out, 1'b0);
		chk(sda_oe_n, 1'b1);
		chk(rd_addr, 15'h0125);
		chk(prog_busy, 1'b0);
		$display("test read done");
	endtask

	task automatic t_brownout();
		int n;
		supply_ok = 1'b0;
		wait_lvl(0, 1'b0, 10, n);
		chk(n < 10, 1'b1);
		chk(sda_oe_n, 1'b1);
		supply_ok = 1'b1;
		wait_lvl(0, 1'b1, PW + 20, n);
		chk(n <= PW + 10, 1'b1);
		$display("test brownout done");
	endtask

	initial begin
		sys_rst = 1'b1;
		supply_ok = 1'b0;
		write_inhibit = 1'b0;
		sel_pins = 3'h0;
		wr_ready = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_powerup();
		t_select();
		t_write_full();
		t_inhibit();
		t_read();
		t_brownout();
		test_done();
	end
endmodule

`default_nettype wire
